// ### rtl/dma_addr_map.sv
`timescale 1ns/1ns
// Contract
// - internal ram holds 256 bytes at data addresses 0x00 to 0xff
// - lower 128 bytes reachable by direct and register-indirect access
// - addresses 0x00-0x1f form four banks of eight registers r0-r7
// - one active bank, chosen by status word bits 4:3, bit 3 low
// - indirect accesses take their index from r0 or r1 of active bank
// - bytes 0x20-0x2f accessible as bytes and as 128 direct bits
// - bit address maps to byte 0x20 plus upper five bits, low three select bit
// - bit or byte access chosen by operand type input for direct addresses up to 0x7f only
// - direct access above 0x7f goes to sfr space, never upper ram
// - indirect access above 0x7f goes to separate upper 128 ram bytes
// - push increments stack pointer first, then stores at new location
// - reset loads stack pointer with 0x07, first push lands at 0x08
// - stack accesses reach all 256 internal bytes with indirect semantics
// - external ram is 4096 or 512 bytes, reached only by external moves
// - pointer external move uses full 16-bit data pointer as address
// - data pointer readable and writable as high and low byte registers
// - 8-bit external move uses page register high, r0 or r1 low
// - page register bits 7:4 read zero, ignore writes; 3:0 read-write
// - each page number selects one 256-byte external ram page
// - external moves target external ram; writes go to flash only if enabled
// - bank n occupies internal addresses 8n through 8n+7
module dma_addr_map
    import dma_pkg::*;
#(
    parameter int EXTERNAL_DATA_RAM_BYTES = EXTERNAL_DATA_RAM_LARGE
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] program_status_word,
    input wire logic acc_req,
    input wire dma_mode_e acc_mode,
    input wire logic acc_write,
    input wire logic acc_is_bit,
    input wire logic acc_bit_val,
    input wire logic [7:0] acc_addr,
    input wire logic acc_use_r1,
    input wire logic acc_data_pointer_16_form,
    input wire logic [7:0] acc_wdata,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic flash_write_redirect,
    output logic [7:0] acc_rdata,
    output logic acc_rbit,
    output logic sfr_req,
    output logic sfr_write,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    output logic flash_wr,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic [7:0] stack_pointer_reg,
    output logic [15:0] data_pointer_16,
    output logic [7:0] external_data_ram_page_select_reg
);
    // only the two fitted ram sizes are served; anything else stops elaboration
    if (EXTERNAL_DATA_RAM_BYTES != EXTERNAL_DATA_RAM_LARGE && EXTERNAL_DATA_RAM_BYTES != EXTERNAL_DATA_RAM_SMALL) begin : g_size_check
        $error("EXTERNAL_DATA_RAM_BYTES must be 4096 or 512");
    end

    localparam int XW = $clog2(EXTERNAL_DATA_RAM_BYTES);

    logic [7:0] iram [IRAM_BYTES];
    logic [7:0] external_data_ram [EXTERNAL_DATA_RAM_BYTES];
    logic [PAGE_W-1:0] page_number_field;
    logic [PAGE_W-1:0] next_page;
    logic [7:0] data_pointer_high, data_pointer_low, next_dph, next_dpl;
    logic [7:0] next_sp;
    logic [1:0] bank;
    logic [7:0] index_val;
    logic [7:0] iaddr;
    logic [15:0] xaddr;
    logic iram_we;
    logic [7:0] iram_wd;
    logic external_data_ram_we;
    logic [7:0] byte_old;
    logic [7:0] next_rdata;
    logic next_rbit;
    logic sp_load;
    logic sp_inc;
    logic sp_dec;
    logic dpl_load;
    logic dph_load;
    logic page_load;
    logic rd_sfr;
    logic rd_iram;
    logic rd_external_data_ram;
    logic rd_bit;
    logic [7:0] reg_read_val;
    logic [7:0] bit_merged;

    function automatic logic [7:0] reg_addr(input logic [1:0] b, input logic [2:0] r);
        reg_addr = {3'h0, b, r};
    endfunction : reg_addr

    // direct addresses above the low half never reach internal ram
    function automatic logic direct_is_sfr(input logic [7:0] a);
        direct_is_sfr = (a > LOW_TOP);
    endfunction : direct_is_sfr

    // byte of the bit-addressable area that holds a bit address
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        bit_byte = BIT_BASE + {3'h0, a[7:3]};
    endfunction : bit_byte

    assign bank = {program_status_word[BANK_HI_POS], program_status_word[BANK_LO_POS]};
    assign index_val = iram[reg_addr(bank, {2'h0, acc_use_r1})];
    assign data_pointer_16 = {data_pointer_high, data_pointer_low};
    assign external_data_ram_page_select_reg = {4'h0, page_number_field};

    // internal address: bit accesses fold onto 0x20-0x2f, stack uses pointer
    always_comb begin
        iaddr = acc_addr;
        if (acc_mode == DMA_STACK) begin
            iaddr = stack_pop ? stack_pointer_reg : stack_pointer_reg + 8'h01;
        end else if (acc_mode == DMA_INDIRECT) begin
            iaddr = index_val;
        end else if (acc_is_bit) begin
            iaddr = bit_byte(acc_addr);
        end
    end

    assign byte_old = iram[iaddr];

    // bit writes are read-modify-write; only the addressed bit takes the new value
    for (genvar gi = 0; gi < 8; gi++) begin : g_bit_merge
        assign bit_merged[gi] = (acc_addr[2:0] == 3'(gi)) ? acc_bit_val : byte_old[gi];
    end

    assign xaddr = acc_data_pointer_16_form ? data_pointer_16 : {external_data_ram_page_select_reg, index_val};

    // access decode: turns one request into strobes for each group of state
    always_comb begin
        sfr_req = 1'b0;
        sfr_write = 1'b0;
        sfr_addr = acc_addr;
        sfr_wdata = acc_wdata;
        iram_we = 1'b0;
        iram_wd = acc_wdata;
        external_data_ram_we = 1'b0;
        flash_wr = 1'b0;
        flash_addr = xaddr;
        flash_wdata = acc_wdata;
        sp_load = 1'b0;
        sp_inc = 1'b0;
        sp_dec = 1'b0;
        dpl_load = 1'b0;
        dph_load = 1'b0;
        page_load = 1'b0;
        rd_sfr = 1'b0;
        rd_iram = 1'b0;
        rd_external_data_ram = 1'b0;
        rd_bit = 1'b0;
        if (acc_req) begin
            case (acc_mode)
                DMA_DIRECT: begin
                    // bit addresses above 0x7f belong to sfr bit space
                    if (direct_is_sfr(acc_addr)) begin
                        sfr_req = 1'b1;
                        sfr_write = acc_write;
                        sp_load = acc_write && (acc_addr == SFR_SP);
                        dpl_load = acc_write && (acc_addr == SFR_DPL);
                        dph_load = acc_write && (acc_addr == SFR_DPH);
                        page_load = acc_write && (acc_addr == SFR_PAGE_SEL);
                        rd_sfr = !acc_write;
                    end else if (acc_is_bit) begin
                        iram_we = acc_write;
                        iram_wd = bit_merged;
                        rd_bit = !acc_write;
                    end else begin
                        iram_we = acc_write;
                        rd_iram = !acc_write;
                    end
                end
                DMA_INDIRECT: begin
                    iram_we = acc_write;
                    rd_iram = !acc_write;
                end
                DMA_STACK: begin
                    if (stack_push) begin
                        iram_we = 1'b1;
                        sp_inc = 1'b1;
                    end else if (stack_pop) begin
                        rd_iram = 1'b1;
                        sp_dec = 1'b1;
                    end
                end
                DMA_XMOVE: begin
                    // reads never follow the flash redirect
                    if (acc_write && flash_write_redirect) begin
                        flash_wr = 1'b1;
                    end else begin
                        external_data_ram_we = acc_write;
                        rd_external_data_ram = !acc_write;
                    end
                end
                default: ;
            endcase
        end
    end

    // sizes beyond the fitted ram alias; upper pointer bits ignored
    always_ff @(posedge core_clk) begin
        if (iram_we) begin
            iram[iaddr] <= iram_wd;
        end
        if (external_data_ram_we) begin
            external_data_ram[xaddr[XW-1:0]] <= acc_wdata;
        end
    end

    // stack pointer: a push goes up first, so the pointer names the last used byte
    // it wraps at 0xff; a deeper stack silently overwrites its own bottom
    always_comb begin
        next_sp = stack_pointer_reg;
        if (sp_load) begin
            next_sp = acc_wdata;
        end else if (sp_inc) begin
            next_sp = stack_pointer_reg + 8'h01;
        end else if (sp_dec) begin
            next_sp = stack_pointer_reg - 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stack_pointer_reg <= SP_RESET;
        end else begin
            stack_pointer_reg <= next_sp;
        end
    end

    // data pointer halves load separately; a 16-bit load is two byte writes
    always_comb begin
        next_dph = data_pointer_high;
        next_dpl = data_pointer_low;
        if (dph_load) begin
            next_dph = acc_wdata;
        end
        if (dpl_load) begin
            next_dpl = acc_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            data_pointer_high <= 8'h00;
            data_pointer_low <= 8'h00;
        end else begin
            data_pointer_high <= next_dph;
            data_pointer_low <= next_dpl;
        end
    end

    // page register keeps only its low nibble; upper write bits are dropped
    always_comb begin
        next_page = page_number_field;
        if (page_load) begin
            next_page = acc_wdata[PAGE_LSB +: PAGE_W];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            page_number_field <= PAGE_SEL_RESET[PAGE_W-1:0];
        end else begin
            page_number_field <= next_page;
        end
    end

    // locally held sfr copies answer from here; everything else comes off the sfr bus
    always_comb begin
        case (acc_addr)
            SFR_SP: reg_read_val = stack_pointer_reg;
            SFR_DPL: reg_read_val = data_pointer_low;
            SFR_DPH: reg_read_val = data_pointer_high;
            SFR_PAGE_SEL: reg_read_val = external_data_ram_page_select_reg;
            default: reg_read_val = sfr_rdata;
        endcase
    end

    // read data holds until the next read so a write cannot disturb it
    always_comb begin
        next_rdata = acc_rdata;
        next_rbit = acc_rbit;
        if (rd_sfr) begin
            next_rdata = reg_read_val;
        end else if (rd_iram) begin
            next_rdata = byte_old;
        end else if (rd_external_data_ram) begin
            next_rdata = external_data_ram[xaddr[XW-1:0]];
        end
        if (rd_bit) begin
            next_rbit = byte_old[acc_addr[2:0]];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc_rdata <= 8'h00;
            acc_rbit <= 1'b0;
        end else begin
            acc_rdata <= next_rdata;
            acc_rbit <= next_rbit;
        end
    end
endmodule : dma_addr_map

// ### shared/dma_pkg.sv
package dma_pkg;
    localparam int IRAM_BYTES = 256;
    localparam logic [7:0] LOW_TOP = 8'h7f;
    localparam logic [7:0] BIT_BASE = 8'h20;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] SFR_SP = 8'h81;
    localparam logic [7:0] SFR_DPL = 8'h82;
    localparam logic [7:0] SFR_DPH = 8'h83;
    localparam logic [7:0] SFR_PAGE_SEL = 8'haa;
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
    localparam int PAGE_LSB = 0;
    localparam int PAGE_W = 4;
    localparam int BANK_LO_POS = 3;
    localparam int BANK_HI_POS = 4;
    localparam int EXTERNAL_DATA_RAM_LARGE = 4096;
    localparam int EXTERNAL_DATA_RAM_SMALL = 512;
    typedef enum logic [4:0] {
        DMA_IDLE = 5'b00001,
        DMA_DIRECT = 5'b00010,
        DMA_INDIRECT = 5'b00100,
        DMA_STACK = 5'b01000,
        DMA_XMOVE = 5'b10000
    } dma_mode_e;
endpackage : dma_pkg

// ### bench/dma_sfr_model.sv
`timescale 1ns/1ns
module dma_sfr_model (
    input wire logic core_clk,
    input wire logic sfr_req,
    input wire logic [7:0] sfr_addr,
    output logic [7:0] sfr_rdata
);
    logic [7:0] junk = 8'h00;
    // outside a request the bus shows a moving pattern, never a stale value
    always @(posedge core_clk) junk <= junk + 8'h01;
    assign sfr_rdata = sfr_req ? (sfr_addr ^ 8'h5a) : junk;
endmodule : dma_sfr_model

// ### bench/dma_addr_map_chk.sv
`timescale 1ns/1ns
module dma_addr_map_chk
    import dma_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic acc_req,
    input wire dma_mode_e acc_mode,
    input wire logic acc_write,
    input wire logic acc_is_bit,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic acc_data_pointer_16_form,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic flash_write_redirect,
    input wire logic sfr_req,
    input wire logic [7:0] sfr_addr,
    input wire logic flash_wr,
    input wire logic [15:0] flash_addr,
    input wire logic [7:0] stack_pointer_reg,
    input wire logic [15:0] data_pointer_16,
    input wire logic [7:0] external_data_ram_page_select_reg,
    input wire logic [7:0] acc_rdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic dwr = acc_req && acc_mode == DMA_DIRECT && acc_write && !acc_is_bit;
    a_push_pre_inc: assert property (acc_req && acc_mode == DMA_STACK && stack_push
        |=> stack_pointer_reg == $past(stack_pointer_reg) + 8'h01) else $error("push sp");
    a_pop_post_dec: assert property (acc_req && acc_mode == DMA_STACK && stack_pop
        |=> stack_pointer_reg == $past(stack_pointer_reg) - 8'h01) else $error("pop sp");
    a_direct_high_sfr: assert property (acc_req && acc_mode == DMA_DIRECT
        && acc_addr > LOW_TOP |-> sfr_req && sfr_addr == acc_addr) else $error("direct high");
    a_direct_low_ram: assert property (acc_req && acc_mode == DMA_DIRECT && !acc_is_bit
        && acc_addr <= LOW_TOP |-> !sfr_req) else $error("direct low");
    a_indirect_no_sfr: assert property (acc_req && acc_mode == DMA_INDIRECT
        |-> !sfr_req) else $error("indirect sfr");
    a_page_upper_zero: assert property (acc_req && acc_mode == DMA_DIRECT && !acc_write
        && acc_addr == SFR_PAGE_SEL |=> acc_rdata[7:4] == 4'h0) else $error("page upper");
    a_sp_reset_val: assert property ($rose(resetn) |-> stack_pointer_reg == SP_RESET)
        else $error("sp reset");
    a_page_write_low: assert property (dwr && acc_addr == SFR_PAGE_SEL
        |=> external_data_ram_page_select_reg == {4'h0, $past(acc_wdata[3:0])}) else $error("page wr");
    a_data_pointer_16_high_wr: assert property (dwr && acc_addr == SFR_DPH
        |=> data_pointer_16[15:8] == $past(acc_wdata)) else $error("dph wr");
    a_flash_redirect: assert property (flash_wr |-> acc_req && acc_write
        && acc_mode == DMA_XMOVE && flash_write_redirect) else $error("flash wr");
    a_flash_data_pointer_16_addr: assert property (flash_wr && acc_data_pointer_16_form
        |-> flash_addr == data_pointer_16) else $error("flash addr");
    c_push: cover property (acc_req && acc_mode == DMA_STACK && stack_push);
    c_sfr: cover property (sfr_req);
    c_flash: cover property (flash_wr);
endmodule : dma_addr_map_chk
bind dma_addr_map dma_addr_map_chk u_chk (.*);

// ### bench/dma_addr_map_tb_top.sv
`timescale 1ns/1ns
module dma_addr_map_tb_top;
    import dma_pkg::*;
    logic core_clk = 0, resetn = 0, acc_req = 0, acc_write = 0, acc_is_bit = 0;
    logic acc_bit_val = 0, acc_use_r1 = 0, acc_data_pointer_16_form = 0, stack_push = 0, stack_pop = 0;
    logic flash_write_redirect = 0, acc_rbit, sfr_req, sfr_write, flash_wr;
    logic [7:0] program_status_word = 0, acc_addr = 0, acc_wdata = 0, acc_rdata, sfr_addr;
    logic [7:0] sfr_wdata, sfr_rdata, flash_wdata, stack_pointer_reg, external_data_ram_page_select_reg;
    logic [15:0] flash_addr, data_pointer_16;
    dma_mode_e acc_mode = DMA_IDLE;
    int miscompares = 0, n_checks = 0, cyc = 0;
    logic [23:0] sfr_cap = 0, fl_cap = 0;
    always #5 core_clk = ~core_clk;
    // comb outputs only stand in the request cycle, so latch them at the taking edge
    always @(posedge core_clk) begin
        if (sfr_req) sfr_cap <= {7'h0, sfr_write, sfr_addr, sfr_wdata};
        if (flash_wr) fl_cap <= {flash_addr, flash_wdata};
    end
    dma_addr_map DUT (.core_clk(core_clk), .resetn(resetn),
        .program_status_word(program_status_word), .acc_req(acc_req), .acc_mode(acc_mode),
        .acc_write(acc_write), .acc_is_bit(acc_is_bit), .acc_bit_val(acc_bit_val),
        .acc_addr(acc_addr), .acc_use_r1(acc_use_r1), .acc_data_pointer_16_form(acc_data_pointer_16_form),
        .acc_wdata(acc_wdata), .stack_push(stack_push), .stack_pop(stack_pop),
        .flash_write_redirect(flash_write_redirect), .acc_rdata(acc_rdata),
        .acc_rbit(acc_rbit), .sfr_req(sfr_req), .sfr_write(sfr_write), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_wr(flash_wr),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .stack_pointer_reg(stack_pointer_reg), .data_pointer_16(data_pointer_16),
        .external_data_ram_page_select_reg(external_data_ram_page_select_reg));
    dma_sfr_model u_sfr (.core_clk(core_clk), .sfr_req(sfr_req), .sfr_addr(sfr_addr),
        .sfr_rdata(sfr_rdata));
    task close_out;
        if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // f = {is_bit, bit_val, use_r1, data_pointer_16_form, push, pop}; one access, request dropped at its taking edge, task returns 1ns later
    task acc(input dma_mode_e m, input logic w, input logic [7:0] a, d, input logic [5:0] f);
        @(posedge core_clk);
        acc_mode <= m;
        {acc_req, acc_write, acc_addr, acc_wdata, acc_is_bit, acc_bit_val,
            acc_use_r1, acc_data_pointer_16_form, stack_push, stack_pop} <= {1'b1, w, a, d, f};
        @(posedge core_clk);
        acc_req <= 1'b0;
        #1;
    endtask : acc
    task wr(input logic [7:0] a, d);
        acc(DMA_DIRECT, 1'b1, a, d, 6'h00);
    endtask : wr
    always @(posedge core_clk) if (++cyc == 3000) begin
        miscompares++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        chk(stack_pointer_reg, 16'h07);
        chk(external_data_ram_page_select_reg, 16'h00);
        acc(DMA_STACK, 1'b1, 8'h00, 8'ha1, 6'b000010);
        chk(stack_pointer_reg, 16'h08);
        acc(DMA_DIRECT, 1'b0, 8'h08, 8'h00, 6'h00);
        chk(acc_rdata, 16'ha1);
        wr(8'h40, 8'h66);
        wr(8'h00, 8'h40);
        wr(8'h10, 8'h85);
        wr(8'h11, 8'h44);
        acc(DMA_INDIRECT, 1'b0, 8'h00, 8'h00, 6'h00);
        chk(acc_rdata, 16'h66);
        @(posedge core_clk) program_status_word <= 8'h10;
        acc(DMA_INDIRECT, 1'b1, 8'h00, 8'h3c, 6'h00);
        acc(DMA_INDIRECT, 1'b0, 8'h00, 8'h00, 6'h00);
        chk(acc_rdata, 16'h3c);
        acc(DMA_DIRECT, 1'b0, 8'h85, 8'h00, 6'h00);
        chk(acc_rdata, 16'h85 ^ 16'h5a);
        wr(8'h22, 8'h00);
        acc(DMA_DIRECT, 1'b1, 8'h13, 8'h00, 6'b110000);
        acc(DMA_DIRECT, 1'b0, 8'h22, 8'h00, 6'h00);
        chk(acc_rdata, 16'h08);
        wr(8'h2f, 8'h80);
        acc(DMA_DIRECT, 1'b0, 8'h7f, 8'h00, 6'b100000);
        chk({15'h0, acc_rbit}, 16'h1);
        wr(SFR_DPH, 8'h03);
        wr(SFR_DPL, 8'h44);
        chk(data_pointer_16, 16'h0344);
        wr(SFR_PAGE_SEL, 8'hf3);
        chk(external_data_ram_page_select_reg, 16'h03);
        chk(sfr_cap, 24'h01aaf3);
        acc(DMA_DIRECT, 1'b0, SFR_PAGE_SEL, 8'h00, 6'h00);
        chk(acc_rdata, 16'h03);
        acc(DMA_XMOVE, 1'b1, 8'h00, 8'h99, 6'b001000);
        acc(DMA_XMOVE, 1'b0, 8'h00, 8'h00, 6'b000100);
        chk(acc_rdata, 16'h99);
        @(posedge core_clk) flash_write_redirect <= 1'b1;
        acc(DMA_XMOVE, 1'b1, 8'h00, 8'h11, 6'b001000);
        chk(fl_cap, 24'h034411);
        acc(DMA_XMOVE, 1'b0, 8'h00, 8'h00, 6'b000100);
        chk(acc_rdata, 16'h99);
        acc(DMA_STACK, 1'b0, 8'h00, 8'h00, 6'b000001);
        chk({acc_rdata, stack_pointer_reg}, 16'ha107);
        close_out();
    end
endmodule : dma_addr_map_tb_top
